// file: tpom_regs.svh
`ifndef TPOM_REGS_SVH
`define TPOM_REGS_SVH

// register indices; byte address is four times the index
`define TPOM_IDX_INBAND       12'ha7d
`define TPOM_IDX_CONFIG       12'ha80
`define TPOM_IDX_ALARM        12'ha81
`define TPOM_IDX_EXPECTED     12'ha82
`define TPOM_IDX_ACCEPTED     12'ha83
`define TPOM_IDX_COUNT_LOW    12'ha84
`define TPOM_IDX_COUNT_HIGH   12'ha85
`define TPOM_IDX_INDICATION   12'haf0

// reset values
`define TPOM_RST_INBAND       7'h00
`define TPOM_RST_CONFIG       6'h00
`define TPOM_RST_ALARM        3'h0
`define TPOM_RST_EXPECTED     3'h0
`define TPOM_CONFIG_RESERVED  1'h1

// indication and enable bit positions
`define TPOM_EV_DEFECT        0
`define TPOM_EV_FAILURE       1
`define TPOM_EV_LABEL_CHANGE  2
`define TPOM_EV_MISMATCH      3
`define TPOM_EV_UNSTABLE      4

// overhead byte fields, index 0 is transmitted bit 8
`define TPOM_V5_DEFECT_BIT    0
`define TPOM_V5_FAILURE_BIT   4
`define TPOM_V5_REI_BIT       5
`define TPOM_Z7_CODE_LSB      1

// persistence counts in multiframes
`define TPOM_PERSIST_SHORT    4'h5
`define TPOM_PERSIST_LONG     4'ha
`define TPOM_LABEL_ACCEPT     4'h5
`define TPOM_UNSTABLE_LIMIT   3'h5

`endif

// file: tpom_pkg.sv
package tpom_pkg;
	typedef logic [2:0]  tpom_label_t;
	typedef logic [10:0] tpom_count_t;
	typedef logic [7:0]  tpom_byte_t;

	typedef enum logic [1:0] {
		TPOM_BUS_IDLE = 2'b00,
		TPOM_BUS_ACK  = 2'b01,
		TPOM_BUS_DONE = 2'b11
	} tpom_bus_state_e;

	function automatic logic tpom_label_mismatch(input tpom_label_t expv,
		input tpom_label_t accv);
		if (expv == 3'h0)
			return accv != 3'h0;
		else if (expv == 3'h1)
			return accv == 3'h0;
		else
			return !((accv == expv) || (accv == 3'h1));
	endfunction
endpackage

// file: tpom_persist.sv
`timescale 1ns/1ps
`include "tpom_regs.svh"
// value filter: state follows input after thresh equal samples
module tpom_persist #(
	parameter int W  = 1,
	parameter int CW = 4
) (
	input  wire logic          ref_clk_in,
	input  wire logic          rstn_in,
	input  wire logic          sample_in,
	input  wire logic [W-1:0]  data_in,
	input  wire logic [CW-1:0] thresh_in,
	output logic      [W-1:0]  state_out,
	output logic               change_out
);
	logic [W-1:0]  cand_reg;
	logic [CW-1:0] cnt_reg;
	wire           same      = (data_in == cand_reg);
	wire [CW-1:0]  cnt_next  = same ? ((cnt_reg >= thresh_in) ? cnt_reg :
		CW'(cnt_reg + 1'b1)) : CW'(1);
	wire           take      = sample_in && (cnt_next >= thresh_in);
	wire           differ    = (data_in != state_out);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cand_reg   <= '0;
			cnt_reg    <= '0;
			state_out  <= '0;
			change_out <= 1'b0;
		end else begin
			change_out <= take && differ;
			if (sample_in) begin
				cand_reg <= data_in;
				cnt_reg  <= cnt_next;
			end
			if (take)
				state_out <= data_in;
		end
	end
endmodule // tpom_persist

// file: tpom_unstable.sv
`timescale 1ns/1ps
`include "tpom_regs.svh"
// label stability watch over consecutive multiframes
module tpom_unstable
	import tpom_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        sample_in,
	input  wire tpom_label_t label_in,
	output logic             unstable_out,
	output logic             change_out
);
	tpom_label_t prev_reg;
	logic [2:0]  diff_reg;
	logic [2:0]  same_reg;
	wire         same      = (label_in == prev_reg);
	wire [2:0]   same_next = same ? 3'(same_reg + 1'b1) : 3'h1;
	wire [2:0]   diff_next = (diff_reg >= `TPOM_UNSTABLE_LIMIT) ? diff_reg :
		3'(diff_reg + 1'b1);
	wire         calm      = same && (same_next >= `TPOM_UNSTABLE_LIMIT);
	wire         rise      = !same && (diff_next >= `TPOM_UNSTABLE_LIMIT);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prev_reg     <= '0;
			diff_reg     <= '0;
			same_reg     <= '0;
			unstable_out <= 1'b0;
			change_out   <= 1'b0;
		end else begin
			change_out <= sample_in && ((calm && unstable_out) ||
				(rise && !unstable_out));
			if (sample_in) begin
				prev_reg <= label_in;
				same_reg <= calm ? 3'h0 : same_next;
				if (calm) begin
					diff_reg     <= 3'h0;
					unstable_out <= 1'b0;
				end else if (!same) begin
					diff_reg <= diff_next;
					if (rise)
						unstable_out <= 1'b1;
				end
			end
		end
	end
endmodule // tpom_unstable

// file: tpom_monitor.sv
`timescale 1ns/1ps
`include "tpom_regs.svh"
module tpom_monitor
	import tpom_pkg::*;
#(
	parameter int TUG2_NUM = 7,
	parameter int ADDR_W   = 14
) (
	input  wire logic              ref_clk_in,
	input  wire logic              rstn_in,
	// register bus
	input  wire logic [ADDR_W-1:0] address_in,
	input  wire logic              read_in,
	input  wire logic              write_in,
	input  wire logic [31:0]       writedata_in,
	input  wire logic [3:0]        byteenable_in,
	output logic      [31:0]       readdata_out,
	output logic                   waitrequest_out,
	// second tributary V5 stream, one TUG2 at a time
	input  wire logic              tu2_v5_valid_in,
	input  wire logic [2:0]        tu2_v5_tug_in,
	input  wire tpom_byte_t        tu2_v5_in,
	input  wire logic              tu2_error_in,
	output logic                   tu2_v5_valid_out,
	output tpom_byte_t             tu2_v5_out,
	// third tributary overhead, one strobe per multiframe
	input  wire logic              mf_strobe_in,
	input  wire tpom_byte_t        v5_in,
	input  wire tpom_byte_t        z7_in,
	input  wire logic [1:0]        parity_error_in,
	input  wire logic              accumulate_in,
	input  wire logic              pointer_loss_in,
	input  wire logic              multiframe_loss_in,
	input  wire logic [3:0]        ais_select_in,
	input  wire logic              persistence_count_select_in,
	input  wire logic              tug2_structure_in,
	output logic                   ais_insert_out,
	output logic                   irq_out
);
	import tpom_pkg::*;

	// ---------------- register state ----------------
	logic [TUG2_NUM-1:0] inband_report_enable_reg;
	logic [5:0]          config_reg;
	logic                tug2_structure_flag_reg;
	logic [2:0]          alarm_ctrl_reg;
	tpom_label_t         expected_label_reg;
	logic [4:0]          indication_reg;
	logic                label_mismatch_status_reg;
	tpom_count_t         count_acc_reg;
	tpom_count_t         count_snap_reg;
	tpom_bus_state_e     bus_state_reg;
	tpom_bus_state_e     bus_state_next;

	// configuration fields
	wire remote_defect_irq_enable  = config_reg[0];
	wire remote_failure_irq_enable = config_reg[1];
	wire label_change_irq_enable   = config_reg[2];
	wire label_mismatch_irq_enable = config_reg[3];
	wire label_unstable_irq_enable = config_reg[4];
	wire block_parity_count_mode   = config_reg[5];
	wire extended_defect_select    = alarm_ctrl_reg[2];
	wire path_terminated_select    = alarm_ctrl_reg[1];

	// ---------------- overhead filtering ----------------
	wire [3:0] persist_count = persistence_count_select_in ?
		`TPOM_PERSIST_LONG : `TPOM_PERSIST_SHORT;
	wire       v5_sample     = mf_strobe_in && !extended_defect_select;
	wire       z7_sample     = mf_strobe_in && extended_defect_select;

	logic        remote_defect_status;
	logic        remote_failure_status;
	tpom_label_t extended_defect_code_status;
	tpom_label_t accepted_label;
	logic        label_unstable_status;
	logic        defect_change;
	logic        failure_change;
	logic        code_change;
	logic        label_change;
	logic        unstable_change;

	tpom_persist #(.W(1), .CW(4)) u_defect (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.sample_in  (v5_sample),
		.data_in    (v5_in[`TPOM_V5_DEFECT_BIT]),
		.thresh_in  (persist_count),
		.state_out  (remote_defect_status),
		.change_out (defect_change)
	);

	tpom_persist #(.W(1), .CW(4)) u_failure (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.sample_in  (v5_sample),
		.data_in    (v5_in[`TPOM_V5_FAILURE_BIT]),
		.thresh_in  (persist_count),
		.state_out  (remote_failure_status),
		.change_out (failure_change)
	);

	tpom_persist #(.W(3), .CW(4)) u_code (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.sample_in  (z7_sample),
		.data_in    (z7_in[`TPOM_Z7_CODE_LSB +: 3]),
		.thresh_in  (persist_count),
		.state_out  (extended_defect_code_status),
		.change_out (code_change)
	);

	tpom_persist #(.W(3), .CW(4)) u_label (
		.ref_clk_in (ref_clk_in),
		.rstn_in    (rstn_in),
		.sample_in  (mf_strobe_in),
		.data_in    (v5_in[3:1]),
		.thresh_in  (`TPOM_LABEL_ACCEPT),
		.state_out  (accepted_label),
		.change_out (label_change)
	);

	tpom_unstable u_unstable (
		.ref_clk_in   (ref_clk_in),
		.rstn_in      (rstn_in),
		.sample_in    (mf_strobe_in),
		.label_in     (v5_in[3:1]),
		.unstable_out (label_unstable_status),
		.change_out   (unstable_change)
	);

	// mismatch state
	wire mismatch_now = tpom_label_mismatch(expected_label_reg,
		accepted_label);
	wire mismatch_change = (mismatch_now != label_mismatch_status_reg);

	// ---------------- events and indications ----------------
	wire [4:0] event_vec;
	assign event_vec[`TPOM_EV_DEFECT]       = extended_defect_select ?
		code_change : defect_change;
	assign event_vec[`TPOM_EV_FAILURE]      = failure_change &&
		!extended_defect_select;
	assign event_vec[`TPOM_EV_LABEL_CHANGE] = label_change;
	assign event_vec[`TPOM_EV_MISMATCH]     = mismatch_change;
	assign event_vec[`TPOM_EV_UNSTABLE]     = unstable_change;

	wire [4:0] irq_enable_vec = {label_unstable_irq_enable,
		label_mismatch_irq_enable, label_change_irq_enable,
		remote_failure_irq_enable && !extended_defect_select,
		remote_defect_irq_enable};

	// ---------------- parity error counting ----------------
	wire [1:0] bit_errors = 2'(parity_error_in[0]) +
		2'(parity_error_in[1]);
	wire [1:0] add_value  = !mf_strobe_in ? 2'h0 :
		(block_parity_count_mode ? 2'(|parity_error_in) : bit_errors);
	wire [11:0] sum_wide  = 12'(count_acc_reg) + 12'(add_value);
	wire tpom_count_t sum_sat = sum_wide[11] ? '1 : sum_wide[10:0];
	wire tpom_count_t add_only = tpom_count_t'(add_value);

	// ---------------- bus decode ----------------
	wire [11:0] reg_index  = address_in[ADDR_W-1:2];
	wire        bus_req    = read_in || write_in;
	wire        bus_commit = (bus_state_reg == TPOM_BUS_ACK) && bus_req;
	wire        wr_commit  = bus_commit && write_in && byteenable_in[0];
	wire        rd_commit  = bus_commit && read_in;
	wire [7:0]  wbyte      = writedata_in[7:0];

	wire hit_inband     = (reg_index == `TPOM_IDX_INBAND);
	wire hit_config     = (reg_index == `TPOM_IDX_CONFIG);
	wire hit_alarm      = (reg_index == `TPOM_IDX_ALARM);
	wire hit_expected   = (reg_index == `TPOM_IDX_EXPECTED);
	wire hit_accepted   = (reg_index == `TPOM_IDX_ACCEPTED);
	wire hit_count_low  = (reg_index == `TPOM_IDX_COUNT_LOW);
	wire hit_count_high = (reg_index == `TPOM_IDX_COUNT_HIGH);
	wire hit_indication = (reg_index == `TPOM_IDX_INDICATION);

	wire [2:0] status_code = extended_defect_select ?
		extended_defect_code_status :
		{1'b0, remote_failure_status, remote_defect_status};

	wire [7:0] rd_inband     = 8'(inband_report_enable_reg);
	wire [7:0] rd_config     = {`TPOM_CONFIG_RESERVED,
		tug2_structure_flag_reg, config_reg};
	wire [7:0] rd_alarm      = {alarm_ctrl_reg, label_unstable_status,
		label_mismatch_status_reg, status_code};
	wire [7:0] rd_expected   = {5'h00, expected_label_reg};
	wire [7:0] rd_accepted   = {5'h00, accepted_label};
	wire [7:0] rd_count_low  = count_snap_reg[7:0];
	wire [7:0] rd_count_high = {5'h00, count_snap_reg[10:8]};
	wire [7:0] rd_indication = {3'h0, indication_reg};

	wire [7:0] rd_byte =
		hit_inband     ? rd_inband     :
		hit_config     ? rd_config     :
		hit_alarm      ? rd_alarm      :
		hit_expected   ? rd_expected   :
		hit_accepted   ? rd_accepted   :
		hit_count_low  ? rd_count_low  :
		hit_count_high ? rd_count_high :
		hit_indication ? rd_indication : 8'h00;

	// only bits already shown to software are cleared
	wire [4:0] ind_clear = (rd_commit && hit_indication) ?
		readdata_out[4:0] : 5'h00;
	wire [4:0] ind_next  = (indication_reg & ~ind_clear) | event_vec;

	// ---------------- bus handshake ----------------
	always_comb begin
		case (bus_state_reg)
			TPOM_BUS_IDLE: bus_state_next = bus_req ? TPOM_BUS_ACK :
				TPOM_BUS_IDLE;
			TPOM_BUS_ACK:  bus_state_next = TPOM_BUS_DONE;
			TPOM_BUS_DONE: bus_state_next = TPOM_BUS_IDLE;
			default:       bus_state_next = TPOM_BUS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_state_reg   <= TPOM_BUS_IDLE;
			waitrequest_out <= 1'b1;
			readdata_out    <= 32'h0000_0000;
		end else begin
			bus_state_reg   <= bus_state_next;
			waitrequest_out <= !(bus_state_next == TPOM_BUS_ACK);
			if (bus_state_reg == TPOM_BUS_IDLE && bus_req)
				readdata_out <= {24'h00_0000, rd_byte};
		end
	end

	// ---------------- software registers ----------------
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			inband_report_enable_reg <= `TPOM_RST_INBAND;
			config_reg               <= `TPOM_RST_CONFIG;
			alarm_ctrl_reg           <= `TPOM_RST_ALARM;
			expected_label_reg       <= `TPOM_RST_EXPECTED;
		end else if (wr_commit) begin
			if (hit_inband)
				inband_report_enable_reg <= wbyte[TUG2_NUM-1:0];
			if (hit_config)
				config_reg <= wbyte[5:0];
			if (hit_alarm)
				alarm_ctrl_reg <= wbyte[7:5];
			if (hit_expected)
				expected_label_reg <= wbyte[2:0];
		end
	end

	// structure strap taken by a clocked process after reset release
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			tug2_structure_flag_reg <= 1'b1;
		else
			tug2_structure_flag_reg <= tug2_structure_in;
	end

	// ---------------- status, counters, indications ----------------
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			indication_reg            <= 5'h00;
			label_mismatch_status_reg <= 1'b0;
			irq_out                   <= 1'b0;
		end else begin
			indication_reg            <= ind_next;
			label_mismatch_status_reg <= mismatch_now;
			irq_out                   <= |(ind_next & irq_enable_vec);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_acc_reg  <= '0;
			count_snap_reg <= '0;
		end else if (accumulate_in) begin
			count_snap_reg <= count_acc_reg;
			count_acc_reg  <= add_only;
		end else begin
			count_acc_reg  <= sum_sat;
		end
	end

	// ---------------- AIS policy ----------------
	wire [3:0] alarm_vec = {label_unstable_status, label_mismatch_status_reg,
		multiframe_loss_in, pointer_loss_in};
	wire ais_terminated = |(alarm_vec & ais_select_in);
	wire ais_through    = |(alarm_vec[1:0] & ais_select_in[1:0]);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			ais_insert_out <= 1'b0;
		else
			ais_insert_out <= path_terminated_select ? ais_terminated :
				ais_through;
	end

	// ---------------- inband reporting on second tributary ----------------
	wire       tug_valid   = (tu2_v5_tug_in < 3'(TUG2_NUM));
	wire       tug_enabled = tug_valid &&
		inband_report_enable_reg[tu2_v5_tug_in];
	tpom_byte_t v5_reported;
	always_comb begin
		v5_reported = tu2_v5_in;
		v5_reported[`TPOM_V5_REI_BIT] = tu2_error_in;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tu2_v5_valid_out <= 1'b0;
			tu2_v5_out       <= 8'h00;
		end else begin
			tu2_v5_valid_out <= tu2_v5_valid_in;
			if (tu2_v5_valid_in)
				tu2_v5_out <= tug_enabled ? v5_reported : tu2_v5_in;
		end
	end
endmodule // tpom_monitor

// file: tpom_monitor_sva.sv
`timescale 1ns/1ps
module tpom_monitor_sva
	import tpom_pkg::*;
(
	input  wire logic                 ref_clk_in,
	input  wire logic                 rstn_in,
	input  wire logic                 read_in,
	input  wire logic                 write_in,
	input  wire logic [31:0]          readdata_out,
	input  wire logic                 waitrequest_out,
	input  wire logic                 tu2_v5_valid_in,
	input  wire tpom_pkg::tpom_byte_t tu2_v5_in,
	input  wire logic                 tu2_error_in,
	input  wire logic                 tu2_v5_valid_out,
	input  wire tpom_pkg::tpom_byte_t tu2_v5_out,
	input  wire logic                 mf_strobe_in,
	input  wire logic [3:0]           ais_select_in,
	input  wire logic                 ais_insert_out,
	input  wire logic                 irq_out
);
	logic [5:0] cause_reg;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	// recent strobes or writes, the only causes of a new interrupt
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			cause_reg <= 6'h00;
		else
			cause_reg <= {cause_reg[4:0], mf_strobe_in | write_in};
	end

	chk_bus_answer: assert property ((read_in || write_in) && waitrequest_out
		|-> ##[1:3] !waitrequest_out) else $error("bus request unanswered");
	chk_wait_pulse: assert property (!waitrequest_out |=> waitrequest_out)
		else $error("waitrequest low too long");
	chk_wait_cause: assert property ($fell(waitrequest_out)
		|-> $past(read_in || write_in)) else $error("answer without request");
	chk_read_hold: assert property (!waitrequest_out |=> $stable(readdata_out))
		else $error("read data not held");
	chk_stream_valid: assert property (tu2_v5_valid_in |=> tu2_v5_valid_out)
		else $error("stream valid lost");
	chk_bits_kept: assert property (
		tu2_v5_valid_in |=> (tu2_v5_out & 8'hdf) == ($past(tu2_v5_in) & 8'hdf))
		else $error("overhead bits altered");
	chk_report_source: assert property (
		tu2_v5_valid_in |=> tu2_v5_out[5] == $past(tu2_v5_in[5])
		|| tu2_v5_out[5] == $past(tu2_error_in))
		else $error("report bit has no source");
	chk_ais_idle: assert property (
		$past(ais_select_in) == 4'h0 |-> !ais_insert_out)
		else $error("ais with nothing selected");
	chk_irq_cause: assert property (
		$rose(irq_out) |-> |cause_reg) else $error("interrupt without cause");
endmodule // tpom_monitor_sva

bind tpom_monitor tpom_monitor_sva u_sva (
	.ref_clk_in, .rstn_in, .read_in, .write_in, .readdata_out,
	.waitrequest_out, .tu2_v5_valid_in, .tu2_v5_in, .tu2_error_in,
	.tu2_v5_valid_out, .tu2_v5_out, .mf_strobe_in, .ais_select_in,
	.ais_insert_out, .irq_out
);

// file: tpom_stream_model.sv
`timescale 1ns/1ps
module tpom_stream_model
	import tpom_pkg::*;
(
	input  wire logic           ref_clk_in,
	output logic                mf_strobe_out,
	output tpom_pkg::tpom_byte_t v5_out,
	output tpom_pkg::tpom_byte_t z7_out,
	output logic [1:0]          parity_error_out
);
	int gap = 4;

	initial begin
		mf_strobe_out = 1'b0;
		v5_out = 8'h00;
		z7_out = 8'h00;
		parity_error_out = 2'h0;
	end

	// overhead is valid only with the strobe; inverted between frames
	task automatic send(input tpom_byte_t v5, input tpom_byte_t z7,
		input logic [1:0] par);
		@(posedge ref_clk_in);
		mf_strobe_out <= 1'b1;
		v5_out <= v5;
		z7_out <= z7;
		parity_error_out <= par;
		@(posedge ref_clk_in);
		mf_strobe_out <= 1'b0;
		v5_out <= ~v5;
		z7_out <= ~z7;
		parity_error_out <= ~par;
		repeat (gap) @(posedge ref_clk_in);
	endtask
endmodule // tpom_stream_model

// file: tpom_monitor_test.sv
`timescale 1ns/1ps
`include "tpom_regs.svh"
module tpom_monitor_test;
	import tpom_pkg::*;

	logic        ref_clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [13:0] address_in = 14'h0000;
	logic        read_in = 1'b0;
	logic        write_in = 1'b0;
	logic [31:0] writedata_in = 32'h0;
	logic [31:0] readdata_out;
	logic        waitrequest_out;
	logic        tu2_v5_valid_in = 1'b0;
	logic [2:0]  tu2_v5_tug_in = 3'h0;
	tpom_byte_t  tu2_v5_in = 8'h00;
	logic        tu2_error_in = 1'b0;
	logic        tu2_v5_valid_out;
	tpom_byte_t  tu2_v5_out;
	logic        mf_strobe_in;
	tpom_byte_t  v5_in;
	tpom_byte_t  z7_in;
	logic [1:0]  parity_error_in;
	logic        accumulate_in = 1'b0;
	logic        pointer_loss_in = 1'b0;
	logic        multiframe_loss_in = 1'b0;
	logic [3:0]  ais_select_in = 4'h0;
	logic        persistence_count_select_in = 1'b0;
	logic        tug2_structure_in = 1'b1;
	logic        ais_insert_out;
	logic        irq_out;
	int          num_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	tpom_byte_t  rd;

	tpom_monitor DUT (.ref_clk_in, .rstn_in, .address_in, .read_in,
		.write_in, .writedata_in, .byteenable_in(4'h1), .readdata_out,
		.waitrequest_out, .tu2_v5_valid_in, .tu2_v5_tug_in, .tu2_v5_in,
		.tu2_error_in, .tu2_v5_valid_out, .tu2_v5_out, .mf_strobe_in,
		.v5_in, .z7_in, .parity_error_in, .accumulate_in, .pointer_loss_in,
		.multiframe_loss_in, .ais_select_in, .persistence_count_select_in,
		.tug2_structure_in, .ais_insert_out, .irq_out);
	tpom_stream_model u_far (.ref_clk_in, .mf_strobe_out(mf_strobe_in),
		.v5_out(v5_in), .z7_out(z7_in), .parity_error_out(parity_error_in));

	initial begin
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			give_verdict;
		end
	end

	task automatic bus(input logic we, input logic [11:0] idx,
		input tpom_byte_t wd);
		@(posedge ref_clk_in);
		address_in <= {idx, 2'b00};
		writedata_in <= {24'h0, wd};
		write_in <= we;
		read_in <= !we;
		do
			@(posedge ref_clk_in);
		while (waitrequest_out !== 1'b0);
		rd = readdata_out[7:0];
		write_in <= 1'b0;
		read_in <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] idx, input tpom_byte_t wd);
		bus(1'b1, idx, wd);
	endtask

	task automatic rc(input logic [11:0] idx, input tpom_byte_t exp);
		bus(1'b0, idx, 8'h00);
		check(rd, exp);
	endtask

	task automatic mf(input int n, input tpom_byte_t v5,
		input tpom_byte_t z7, input logic [1:0] p);
		repeat (n) u_far.send(v5, z7, p);
	endtask

	task automatic settle;
		repeat (4) @(posedge ref_clk_in);
	endtask

	task automatic tu(input logic [2:0] g, input tpom_byte_t b,
		input logic e, input tpom_byte_t exp);
		@(posedge ref_clk_in);
		tu2_v5_valid_in <= 1'b1;
		tu2_v5_tug_in <= g;
		tu2_v5_in <= b;
		tu2_error_in <= e;
		@(posedge ref_clk_in);
		tu2_v5_valid_in <= 1'b0;
		tu2_v5_in <= ~b;
		@(negedge ref_clk_in);
		check({7'h0, tu2_v5_valid_out, tu2_v5_out}, {8'h01, exp});
	endtask

	task automatic t_regs;
		rc(`TPOM_IDX_INBAND, 8'h00);
		rc(`TPOM_IDX_CONFIG, 8'hc0);
		rc(12'h100, 8'h00);
		wr(`TPOM_IDX_INBAND, 8'hff);
		rc(`TPOM_IDX_INBAND, 8'h7f);
		tug2_structure_in <= 1'b0;
		rc(`TPOM_IDX_CONFIG, 8'h80);
		wr(`TPOM_IDX_ACCEPTED, 8'h07);
		rc(`TPOM_IDX_ACCEPTED, 8'h00);
		$display("registers done");
	endtask

	task automatic t_inband;
		for (int g = 0; g < 7; g++)
			tu(g[2:0], 8'h00, 1'b1, 8'h20);
		wr(`TPOM_IDX_INBAND, 8'h04);
		tu(3'd2, 8'hff, 1'b0, 8'hdf);
		tu(3'd3, 8'h00, 1'b1, 8'h00);
		tu(3'd6, 8'hda, 1'b1, 8'hda);
		$display("inband done");
	endtask

	task automatic t_label;
		tpom_label_t e[5] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h7};
		logic m[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		wr(`TPOM_IDX_EXPECTED, 8'h02);
		settle;
		check(irq_out, 1'b0);
		rc(`TPOM_IDX_ALARM, 8'h08);
		rc(`TPOM_IDX_INDICATION, 8'h08);
		rc(`TPOM_IDX_INDICATION, 8'h00);
		wr(`TPOM_IDX_CONFIG, 8'h9c);
		mf(4, 8'h0a, 8'h00, 2'h0);
		rc(`TPOM_IDX_ACCEPTED, 8'h00);
		mf(1, 8'h0a, 8'h00, 2'h0);
		rc(`TPOM_IDX_ACCEPTED, 8'h05);
		check(irq_out, 1'b1);
		rc(`TPOM_IDX_INDICATION, 8'h04);
		for (int i = 0; i < 5; i++) begin
			wr(`TPOM_IDX_EXPECTED, {5'h0, e[i]});
			rc(`TPOM_IDX_ALARM, {4'h0, m[i], 3'h0});
		end
		rc(`TPOM_IDX_INDICATION, 8'h08);
		$display("label done");
	endtask

	task automatic t_unstable;
		for (int i = 0; i < 4; i++)
			mf(1, i[0] ? 8'h04 : 8'h02, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h08);
		mf(1, 8'h02, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h18);
		check(irq_out, 1'b1);
		rc(`TPOM_IDX_INDICATION, 8'h10);
		mf(6, 8'h06, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h08);
		rc(`TPOM_IDX_INDICATION, 8'h14);
		$display("unstable done");
	endtask

	task automatic t_defect;
		wr(`TPOM_IDX_CONFIG, 8'h81);
		mf(4, 8'h07, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h08);
		mf(1, 8'h07, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h09);
		check(irq_out, 1'b1);
		rc(`TPOM_IDX_INDICATION, 8'h01);
		mf(5, 8'h06, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h08);
		rc(`TPOM_IDX_INDICATION, 8'h01);
		persistence_count_select_in <= 1'b1;
		wr(`TPOM_IDX_CONFIG, 8'h83);
		mf(9, 8'h16, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h08);
		mf(1, 8'h16, 8'h00, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h0a);
		check(irq_out, 1'b1);
		// pending failure indication must stop driving the interrupt
		wr(`TPOM_IDX_ALARM, 8'h80);
		settle;
		check(irq_out, 1'b0);
		rc(`TPOM_IDX_INDICATION, 8'h02);
		mf(9, 8'h16, 8'h0a, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h88);
		mf(1, 8'h16, 8'h0a, 2'h0);
		rc(`TPOM_IDX_ALARM, 8'h8d);
		rc(`TPOM_IDX_INDICATION, 8'h01);
		wr(`TPOM_IDX_ALARM, 8'h00);
		$display("defect done");
	endtask

	task automatic t_bip;
		u_far.gap = 0;
		acc();
		mf(3, 8'h06, 8'h00, 2'h3);
		mf(1, 8'h06, 8'h00, 2'h1);
		acc();
		rc(`TPOM_IDX_COUNT_LOW, 8'h07);
		rc(`TPOM_IDX_COUNT_HIGH, 8'h00);
		wr(`TPOM_IDX_CONFIG, 8'ha1);
		mf(3, 8'h06, 8'h00, 2'h3);
		mf(1, 8'h06, 8'h00, 2'h1);
		acc();
		rc(`TPOM_IDX_COUNT_LOW, 8'h04);
		wr(`TPOM_IDX_CONFIG, 8'h81);
		mf(1030, 8'h06, 8'h00, 2'h3);
		acc();
		rc(`TPOM_IDX_COUNT_LOW, 8'hff);
		rc(`TPOM_IDX_COUNT_HIGH, 8'h07);
		u_far.gap = 4;
		$display("parity count done");
	endtask

	task automatic acc;
		@(posedge ref_clk_in);
		accumulate_in <= 1'b1;
		@(posedge ref_clk_in);
		accumulate_in <= 1'b0;
	endtask

	task automatic t_ais;
		ais_select_in <= 4'hf;
		settle;
		check(ais_insert_out, 1'b0);
		multiframe_loss_in <= 1'b1;
		settle;
		check(ais_insert_out, 1'b1);
		multiframe_loss_in <= 1'b0;
		wr(`TPOM_IDX_ALARM, 8'h40);
		settle;
		check(ais_insert_out, 1'b1);
		ais_select_in <= 4'h3;
		settle;
		check(ais_insert_out, 1'b0);
		ais_select_in <= 4'h0;
		$display("ais done");
	endtask

	initial begin
		repeat (8) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		t_regs();
		t_inband();
		t_label();
		t_unstable();
		t_defect();
		t_bip();
		t_ais();
		give_verdict;
	end
endmodule // tpom_monitor_test
